// >>> hdl/osc_config_map.svh
// Offsets, field positions and encodings of the oscillator configuration block
`ifndef OSC_CONFIG_MAP_SVH
`define OSC_CONFIG_MAP_SVH

// Register byte offsets
`define OCM_SRC_CFG_OFS       4'h0
`define OCM_MODE_CFG_OFS      4'h4
`define OCM_CTRL_OFS          4'h8
`define OCM_STAT_OFS          4'hC

// Erased configuration word value
`define OCM_ERASED_WORD       16'hFFFF

// Source selection word fields
`define OCM_SRC_SEL_LSB       0
`define OCM_TWO_SPEED_BIT     7

// Mode word fields
`define OCM_PRIM_MODE_LSB     0
`define OCM_PIN2_FUNC_BIT     2
`define OCM_ONE_WAY_BIT       5
`define OCM_CSM_LSB           6

// Source selection codes
`define OCM_SRC_FAST_RC       3'h0
`define OCM_SRC_FAST_RC_PLL   3'h1
`define OCM_SRC_PRIMARY       3'h2
`define OCM_SRC_PRIMARY_PLL   3'h3
`define OCM_SRC_SECONDARY     3'h4
`define OCM_SRC_LOW_POWER_RC  3'h5
`define OCM_SRC_FAST_RC_DIV16 3'h6
`define OCM_SRC_FAST_RC_DIVN  3'h7

// Primary oscillator mode codes
`define OCM_PRIM_EXT_CLOCK    2'h0
`define OCM_PRIM_MEDIUM_XTAL  2'h1
`define OCM_PRIM_HIGH_XTAL    2'h2
`define OCM_PRIM_DISABLED     2'h3

// Control register fields
`define OCM_CTRL_NEW_SRC_LSB  0
`define OCM_CTRL_SWITCH_BIT   3
`define OCM_CTRL_PIN_LOCK_BIT 4
`define OCM_CTRL_GPIO_OUT_BIT 5
`define OCM_CTRL_GPIO_OE_BIT  6

// Status register fields
`define OCM_STAT_CUR_SRC_LSB  0
`define OCM_STAT_FAIL_BIT     4
`define OCM_STAT_TWO_SPD_BIT  5
`define OCM_STAT_SW_EN_BIT    6
`define OCM_STAT_MON_EN_BIT   7
`define OCM_STAT_VARIANT_LSB  8
`define OCM_STAT_XTAL_BIT     11
`define OCM_STAT_PPS_DONE_BIT 12

// Bus responses
`define OCM_RESP_OKAY         2'h0
`define OCM_RESP_SLVERR       2'h2

`endif

// >>> hdl/osc_config_pkg.sv
// Types shared by the oscillator configuration block
`default_nettype none
package osc_config_pkg;
  typedef enum logic [1:0] {
    BOOT_CAPTURE,
    BOOT_FAST_RC,
    BOOT_RUN
  } boot_state_t;

  typedef enum logic [2:0] {
    VAR_NONE,
    VAR_EXT_CLOCK,
    VAR_MEDIUM_XTAL,
    VAR_HIGH_XTAL,
    VAR_EXT_CLOCK_PLL,
    VAR_MEDIUM_XTAL_PLL,
    VAR_HIGH_XTAL_PLL
  } prim_variant_t;

  typedef logic [2:0]  src_sel_t;
  typedef logic [15:0] cfg_word_t;
endpackage
`default_nettype wire

// >>> hdl/osc_config_source_select.sv
// Oscillator configuration decode, reset source selection and register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "osc_config_map.svh"

// Notes on behaviour
// R1 - Instruction clock is system clock halved
// R2 - Reset source from selection field; switching afterwards
// R3 - Decode eight source selection codes
// R4 - Erased configuration selects fast RC divide-by-N
// R5 - Decode two-bit primary oscillator mode field
// R6 - Primary PLL variant chosen by mode field
// R7 - Pin two: clock out or GPIO, not crystals; code tests the active source, so crystal modes free the pin on fast RC
// R8 - Decode clock switch and monitor enables
// R9 - Two-speed start: fast RC, then selected
// R10 - One-way bit limits pin mapping to once
// R11 - Programmer writes reserved bits as one
// R12 - Config words come from program memory
// R13 - Latch decoded configuration until power-on reset
module osc_config_source_select (
  input  wire logic                       aclk,             // System clock
  input  wire logic                       aresetn,          // Power-on reset, active low
  input  wire osc_config_pkg::cfg_word_t  nv_src_word,      // Source selection word from program memory
  input  wire osc_config_pkg::cfg_word_t  nv_mode_word,     // Mode word from program memory
  input  wire logic                       nv_programmed,    // Low while the configuration is erased
  input  wire logic                       source_ready,     // Requested source is stable
  input  wire logic                       clock_fail,       // Active source has failed
  input  wire logic                       osc_pin2_i,       // Second oscillator pin input
  output logic                            osc_pin2_o,       // Second oscillator pin output
  output logic                            osc_pin2_oe,      // Second oscillator pin drive enable
  output logic                            instr_clk_en,     // One-cycle instruction clock enable
  output osc_config_pkg::src_sel_t        active_source,    // Source now clocking the device
  output osc_config_pkg::src_sel_t        requested_source, // Source being started
  output osc_config_pkg::prim_variant_t   primary_variant,  // Primary oscillator variant in use
  output logic                            switch_enable,    // Clock switching permitted
  output logic                            monitor_enable,   // Fail-safe monitor enabled
  output logic                            pin_map_locked,   // Peripheral pin mapping locked
  input  wire logic [3:0]                 s_axi_awaddr,     // Write address
  input  wire logic                       s_axi_awvalid,    // Write address valid
  output logic                            s_axi_awready,    // Write address ready
  input  wire logic [31:0]                s_axi_wdata,      // Write data
  input  wire logic [3:0]                 s_axi_wstrb,      // Write byte strobes
  input  wire logic                       s_axi_wvalid,     // Write data valid
  output logic                            s_axi_wready,     // Write data ready
  output logic [1:0]                      s_axi_bresp,      // Write response
  output logic                            s_axi_bvalid,     // Write response valid
  input  wire logic                       s_axi_bready,     // Write response ready
  input  wire logic [3:0]                 s_axi_araddr,     // Read address
  input  wire logic                       s_axi_arvalid,    // Read address valid
  output logic                            s_axi_arready,    // Read address ready
  output logic [31:0]                     s_axi_rdata,      // Read data
  output logic [1:0]                      s_axi_rresp,      // Read response
  output logic                            s_axi_rvalid,     // Read data valid
  input  wire logic                       s_axi_rready      // Read response ready
);
  import osc_config_pkg::*;

  function automatic prim_variant_t variant_of(input src_sel_t src, input logic [1:0] mode);
    prim_variant_t v;
    v = VAR_NONE;
    if (src == `OCM_SRC_PRIMARY || src == `OCM_SRC_PRIMARY_PLL) begin
      case (mode) // R5
        `OCM_PRIM_EXT_CLOCK:   v = (src == `OCM_SRC_PRIMARY) ? VAR_EXT_CLOCK : VAR_EXT_CLOCK_PLL; // R6
        `OCM_PRIM_MEDIUM_XTAL: v = (src == `OCM_SRC_PRIMARY) ? VAR_MEDIUM_XTAL : VAR_MEDIUM_XTAL_PLL; // R6
        `OCM_PRIM_HIGH_XTAL:   v = (src == `OCM_SRC_PRIMARY) ? VAR_HIGH_XTAL : VAR_HIGH_XTAL_PLL; // R6
        default:               v = VAR_NONE;
      endcase
    end
    return v;
  endfunction

  function automatic logic is_crystal(input prim_variant_t v);
    return v == VAR_MEDIUM_XTAL || v == VAR_HIGH_XTAL || v == VAR_MEDIUM_XTAL_PLL || v == VAR_HIGH_XTAL_PLL;
  endfunction

  // Latched configuration
  boot_state_t   boot_q,      boot_d;
  cfg_word_t     src_cfg_q,   src_cfg_d;
  cfg_word_t     mode_cfg_q,  mode_cfg_d;
  src_sel_t      cur_src_q,   cur_src_d;
  src_sel_t      req_src_q,   req_src_d;
  logic          switching_q, switching_d;
  logic          fail_q,      fail_d;
  logic          div_q,       div_d;
  logic          pin_lock_q,  pin_lock_d;
  logic          pps_done_q,  pps_done_d;
  logic [2:0]    ctrl_src_q,  ctrl_src_d;
  logic          gpio_out_q,  gpio_out_d;
  logic          gpio_oe_q,   gpio_oe_d;
  // Bus state
  logic          aw_held_q,   aw_held_d;
  logic [3:0]    aw_addr_q,   aw_addr_d;
  logic          w_held_q,    w_held_d;
  logic [31:0]   w_data_q,    w_data_d;
  logic [3:0]    w_strb_q,    w_strb_d;
  logic          bvalid_q,    bvalid_d;
  logic [1:0]    bresp_q,     bresp_d;
  logic          rvalid_q,    rvalid_d;
  logic [31:0]   rdata_q,     rdata_d;
  logic [1:0]    rresp_q,     rresp_d;
  logic          sw_en;
  logic          mon_en;
  logic          one_way;
  logic          pin2_func;
  prim_variant_t variant;
  logic          wr_fire;
  logic [31:0]   stat_word;
  logic [31:0]   ctrl_word;

  // Decoded configuration fields
  always_comb begin
    sw_en     = ~mode_cfg_q[`OCM_CSM_LSB + 1]; // R8
    mon_en    = mode_cfg_q[`OCM_CSM_LSB + 1 -: 2] == 2'h0; // R8
    one_way   = mode_cfg_q[`OCM_ONE_WAY_BIT];
    pin2_func = mode_cfg_q[`OCM_PIN2_FUNC_BIT];
    variant   = variant_of(cur_src_q, mode_cfg_q[`OCM_PRIM_MODE_LSB +: 2]);
    wr_fire   = aw_held_q && w_held_q && !bvalid_q;
    ctrl_word = {25'h000_0000, gpio_oe_q, gpio_out_q, pin_lock_q, switching_q, ctrl_src_q};
    stat_word = {19'h0_0000, pps_done_q, is_crystal(variant), variant, mon_en, sw_en,
                 boot_q == BOOT_FAST_RC, fail_q, 1'b0, cur_src_q};
  end

  // Clock source selection and configuration latch
  always_comb begin
    boot_d      = boot_q;
    src_cfg_d   = src_cfg_q;
    mode_cfg_d  = mode_cfg_q;
    cur_src_d   = cur_src_q;
    req_src_d   = req_src_q;
    switching_d = switching_q;
    fail_d      = fail_q;
    div_d       = ~div_q; // R1
    pin_lock_d  = pin_lock_q;
    pps_done_d  = pps_done_q;
    ctrl_src_d  = ctrl_src_q;
    gpio_out_d  = gpio_out_q;
    gpio_oe_d   = gpio_oe_q;
    case (boot_q)
      BOOT_CAPTURE: begin
        // Words are sampled once after reset release and then frozen
        src_cfg_d  = nv_programmed ? nv_src_word : `OCM_ERASED_WORD; // R12 R13 R4
        mode_cfg_d = nv_programmed ? nv_mode_word : `OCM_ERASED_WORD; // R12 R13 R4
        req_src_d  = src_cfg_d[`OCM_SRC_SEL_LSB +: 3]; // R2 R3
        if (src_cfg_d[`OCM_TWO_SPEED_BIT]) begin
          cur_src_d = `OCM_SRC_FAST_RC; // R9
          boot_d    = BOOT_FAST_RC;
        end else begin
          cur_src_d = src_cfg_d[`OCM_SRC_SEL_LSB +: 3]; // R2 R9
          boot_d    = BOOT_RUN;
        end
      end
      BOOT_FAST_RC: begin
        if (source_ready) begin
          cur_src_d = req_src_q; // R9
          boot_d    = BOOT_RUN;
        end
      end
      BOOT_RUN: begin
        if (switching_q && source_ready) begin
          cur_src_d   = req_src_q; // R2
          switching_d = 1'b0;
        end
      end
      default: boot_d = BOOT_CAPTURE;
    endcase
    if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == `OCM_CTRL_OFS) begin
        ctrl_src_d = w_data_q[`OCM_CTRL_NEW_SRC_LSB +: 3];
        gpio_out_d = w_data_q[`OCM_CTRL_GPIO_OUT_BIT];
        gpio_oe_d  = w_data_q[`OCM_CTRL_GPIO_OE_BIT];
        // Switch requests only after start-up and only while permitted
        if (w_data_q[`OCM_CTRL_SWITCH_BIT] && sw_en && boot_q == BOOT_RUN && !switching_q) begin
          req_src_d   = w_data_q[`OCM_CTRL_NEW_SRC_LSB +: 3]; // R2
          switching_d = 1'b1;
        end
        if (w_data_q[`OCM_CTRL_PIN_LOCK_BIT]) begin
          pin_lock_d = 1'b1;
          pps_done_d = 1'b1; // R10
        end else if (!(one_way && pps_done_q)) begin
          pin_lock_d = 1'b0; // R10
        end
      end else if (aw_addr_q == `OCM_STAT_OFS && w_data_q[`OCM_STAT_FAIL_BIT]) begin
        fail_d = 1'b0;
      end
    end
    // Monitor falls back to fast RC; a failure beats a same-cycle clear
    if (clock_fail && mon_en && boot_q != BOOT_CAPTURE) begin
      fail_d      = 1'b1; // R8
      cur_src_d   = `OCM_SRC_FAST_RC;
      req_src_d   = `OCM_SRC_FAST_RC;
      switching_d = 1'b0;
      boot_d      = BOOT_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q      <= BOOT_CAPTURE;
      src_cfg_q   <= `OCM_ERASED_WORD;
      mode_cfg_q  <= `OCM_ERASED_WORD;
      cur_src_q   <= `OCM_SRC_FAST_RC_DIVN;
      req_src_q   <= `OCM_SRC_FAST_RC_DIVN;
      switching_q <= 1'b0;
      fail_q      <= 1'b0;
      div_q       <= 1'b0;
      pin_lock_q  <= 1'b0;
      pps_done_q  <= 1'b0;
      ctrl_src_q  <= `OCM_SRC_FAST_RC;
      gpio_out_q  <= 1'b0;
      gpio_oe_q   <= 1'b0;
    end else begin
      boot_q      <= boot_d;
      src_cfg_q   <= src_cfg_d;
      mode_cfg_q  <= mode_cfg_d;
      cur_src_q   <= cur_src_d;
      req_src_q   <= req_src_d;
      switching_q <= switching_d;
      fail_q      <= fail_d;
      div_q       <= div_d;
      pin_lock_q  <= pin_lock_d;
      pps_done_q  <= pps_done_d;
      ctrl_src_q  <= ctrl_src_d;
      gpio_out_q  <= gpio_out_d;
      gpio_oe_q   <= gpio_oe_d;
    end
  end

  // Register bus slave
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (aw_addr_q == `OCM_CTRL_OFS || aw_addr_q == `OCM_STAT_OFS || aw_addr_q == `OCM_SRC_CFG_OFS
          || aw_addr_q == `OCM_MODE_CFG_OFS) begin
        bresp_d = `OCM_RESP_OKAY; // R12
      end else begin
        bresp_d = `OCM_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `OCM_RESP_OKAY;
      if (s_axi_araddr == `OCM_SRC_CFG_OFS) begin
        rdata_d = {16'h0000, src_cfg_q};
      end else if (s_axi_araddr == `OCM_MODE_CFG_OFS) begin
        rdata_d = {16'h0000, mode_cfg_q};
      end else if (s_axi_araddr == `OCM_CTRL_OFS) begin
        rdata_d = ctrl_word;
      end else if (s_axi_araddr == `OCM_STAT_OFS) begin
        rdata_d = stat_word;
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = `OCM_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `OCM_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `OCM_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Outputs
  always_comb begin
    s_axi_awready    = !aw_held_q;
    s_axi_wready     = !w_held_q;
    s_axi_bvalid     = bvalid_q;
    s_axi_bresp      = bresp_q;
    s_axi_arready    = !rvalid_q;
    s_axi_rvalid     = rvalid_q;
    s_axi_rdata      = rdata_q;
    s_axi_rresp      = rresp_q;
    instr_clk_en     = div_q; // R1
    active_source    = cur_src_q;
    requested_source = req_src_q;
    primary_variant  = variant;
    switch_enable    = sw_en;
    monitor_enable   = mon_en;
    pin_map_locked   = pin_lock_q;
    if (is_crystal(variant) || boot_q == BOOT_CAPTURE) begin
      osc_pin2_o  = 1'b0; // R7
      osc_pin2_oe = 1'b0;
    end else if (pin2_func) begin
      osc_pin2_o  = div_q; // R7
      osc_pin2_oe = 1'b1;
    end else begin
      osc_pin2_o  = gpio_out_q; // R7
      osc_pin2_oe = gpio_oe_q;
    end
  end

  logic unused_pin;
  assign unused_pin = osc_pin2_i;
endmodule
`default_nettype wire

// >>> tb/osc_config_source_select_bench.sv
// Self-checking bench for the oscillator configuration block
`timescale 1ns/1ps
`default_nettype none
module osc_config_source_select_bench;
  import osc_config_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  cfg_word_t     nv_src_word = 16'hffff;
  cfg_word_t     nv_mode_word = 16'hffff;
  logic          nv_programmed = 1'b1;
  logic          source_ready = 1'b0;
  logic          clock_fail = 1'b0;
  logic          osc_pin2_i = 1'b0;
  logic [3:0]    s_axi_awaddr = 4'h0;
  logic [3:0]    s_axi_araddr = 4'h0;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic [31:0]   s_axi_wdata = 32'h0000_0000;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_wvalid = 1'b0;
  logic          s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_rready = 1'b0;
  logic          osc_pin2_o, osc_pin2_oe, instr_clk_en, switch_enable, monitor_enable, pin_map_locked;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [31:0]   s_axi_rdata;
  src_sel_t      active_source, requested_source;
  prim_variant_t primary_variant;
  logic [33:0]   exp_r[$];
  logic [1:0]    exp_b[$];
  logic [31:0]   rng = 32'h0000_32db;
  int            n_mismatch = 0;
  int            compares = 0;

  osc_config_source_select osc_config_source_select_i (.*);

  initial forever #25 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected status word: source, fail, two-speed, switch mode field, variant
  function automatic logic [33:0] stat(input src_sel_t c, input logic f, input logic t,
                                       input logic [1:0] k, input prim_variant_t v);
    logic x;
    x = v inside {VAR_MEDIUM_XTAL, VAR_HIGH_XTAL, VAR_MEDIUM_XTAL_PLL, VAR_HIGH_XTAL_PLL};
    return {22'h00_0000, x, v, k == 2'h0, !k[1], t, f, 1'b0, c};
  endfunction

  function automatic prim_variant_t pv(input src_sel_t c, input logic [1:0] m);
    if (m == 2'h3 || c[2:1] != 2'h1) return VAR_NONE;
    return prim_variant_t'(c[0] ? 3'h4 + {1'b0, m} : 3'h1 + {1'b0, m});
  endfunction

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic boot(input cfg_word_t s, input cfg_word_t m, input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    nv_src_word <= s;
    nv_mode_word <= m;
    nv_programmed <= p;
    source_ready <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    exp_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Responses are compared against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0000_0000, s_axi_bresp}, {32'h0000_0000, exp_b.pop_front()});
  end

  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r;
    src_sel_t    c;
    logic [1:0]  md;
    cfg_word_t   sw;
    cfg_word_t   mw;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      c = i[3] ? {2'b01, i[0]} : i[2:0];
      md = i[3] ? i[2:1] : r[1:0];
      sw = {8'hff, 1'b0, 4'hf, c};
      mw = {8'hff, r[3:2], r[4], 2'h3, r[5], md};
      boot(sw, mw, 1'b1);
      rd(4'h0, {18'h0_0000, sw});
      rd(4'h4, {18'h0_0000, mw});
      rd(4'hc, stat(c, 1'b0, 1'b0, r[3:2], pv(c, md)));
    end
    $display("boot sweep done");
    r = rnd();
    boot(r[15:0], r[31:16], 1'b0);
    rd(4'h0, {18'h0_0000, 16'hffff});
    rd(4'hc, stat(3'h0, 1'b0, 1'b1, 2'h3, VAR_NONE));
    source_ready <= 1'b1;
    rd(4'hc, stat(3'h7, 1'b0, 1'b0, 2'h3, VAR_NONE));
    wr(4'h0, 32'h0000_1234, 4'hf, 2'h0);
    rd(4'h0, {18'h0_0000, 16'hffff});
    wr(4'h8, 32'h0000_000c, 4'hf, 2'h0);
    rd(4'hc, stat(3'h7, 1'b0, 1'b0, 2'h3, VAR_NONE));
    rd(4'h2, {2'h2, 32'h0000_0000});
    wr(4'h6, 32'h0000_0001, 4'hf, 2'h2);
    $display("erased start done");
    boot(16'hfffa, 16'hff3e, 1'b1);
    rd(4'hc, stat(3'h0, 1'b0, 1'b1, 2'h0, VAR_NONE));
    source_ready <= 1'b1;
    rd(4'hc, stat(3'h2, 1'b0, 1'b0, 2'h0, VAR_HIGH_XTAL));
    source_ready <= 1'b0;
    clock_fail <= 1'b1;
    @(posedge aclk);
    clock_fail <= 1'b0;
    rd(4'hc, stat(3'h0, 1'b1, 1'b0, 2'h0, VAR_NONE));
    wr(4'hc, 32'h0000_0010, 4'hf, 2'h0);
    source_ready <= 1'b1;
    wr(4'h8, 32'h0000_000d, 4'hf, 2'h0);
    rd(4'hc, stat(3'h5, 1'b0, 1'b0, 2'h0, VAR_NONE));
    wr(4'h8, 32'h0000_000c, 4'he, 2'h0);
    rd(4'h8, {2'h0, 32'h0000_0005});
    wr(4'h8, 32'h0000_0015, 4'hf, 2'h0);
    wr(4'h8, 32'h0000_0005, 4'hf, 2'h0);
    rd(4'h8, {2'h0, 32'h0000_0015});
    $display("two-speed, fail and switch done");
    boot(16'hff7a, 16'hff1e, 1'b1);
    wr(4'h8, 32'h0000_0012, 4'hf, 2'h0);
    wr(4'h8, 32'h0000_0002, 4'hf, 2'h0);
    rd(4'h8, {2'h0, 32'h0000_0002});
    $display("pin lock reuse done");
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule

bind osc_config_source_select osc_config_source_select_chk osc_config_source_select_chk_i (.*);
`default_nettype wire

// >>> tb/osc_config_source_select_chk.sv
// Assertion checker for the oscillator configuration block
`timescale 1ns/1ps
`default_nettype none
module osc_config_source_select_chk (
  input wire logic                          aclk,             // Clock
  input wire logic                          aresetn,          // Reset
  input wire osc_config_pkg::cfg_word_t     nv_src_word,      // Source word
  input wire osc_config_pkg::cfg_word_t     nv_mode_word,     // Mode word
  input wire logic                          nv_programmed,    // Words valid
  input wire logic                          source_ready,     // Source stable
  input wire logic                          clock_fail,       // Source failed
  input wire logic                          osc_pin2_oe,      // Pin drive
  input wire logic                          osc_pin2_o,       // Pin output
  input wire logic                          instr_clk_en,     // Cycle enable
  input wire osc_config_pkg::src_sel_t      active_source,    // Current source
  input wire osc_config_pkg::src_sel_t      requested_source, // Target source
  input wire osc_config_pkg::prim_variant_t primary_variant,  // Primary variant
  input wire logic                          switch_enable,    // Switching on
  input wire logic                          monitor_enable,   // Monitor on
  input wire logic                          pin_map_locked    // Pin map lock
);
  import osc_config_pkg::*;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       up;
  logic       xtal;
  logic [1:0] md;
  always_comb cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 2'h0;
    else cnt_q <= cnt_d;
  end
  assign up = cnt_q >= 2'h2;
  assign md = nv_mode_word[1:0];
  assign xtal = primary_variant inside {VAR_MEDIUM_XTAL, VAR_HIGH_XTAL, VAR_MEDIUM_XTAL_PLL, VAR_HIGH_XTAL_PLL};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Boot finished with a pending start, no clock failure and the monitor off
  sequence start_wait;
    up && active_source != requested_source && !clock_fail && !monitor_enable;
  endsequence
  a_fcy_half: assert property (up |=> instr_clk_en != $past(instr_clk_en))
    else $error("instruction enable did not alternate");
  a_boot_direct: assert property (cnt_q == 2'h2 && nv_programmed && !nv_src_word[7]
    |-> active_source == nv_src_word[2:0]) else $error("reset source not taken");
  a_boot_two_speed: assert property (cnt_q == 2'h2 && (!nv_programmed || nv_src_word[7]) && !source_ready
    |-> active_source == 3'h0) else $error("two-speed start not on fast RC");
  a_erased_default: assert property (cnt_q == 2'h2 && !nv_programmed
    |-> requested_source == 3'h7 && !switch_enable) else $error("erased default wrong");
  a_switch_decode: assert property (up && nv_programmed |-> switch_enable == !nv_mode_word[7]
    && monitor_enable == (nv_mode_word[7:6] == 2'h0)) else $error("switch mode decode wrong");
  a_pll_variant: assert property (up && nv_programmed && active_source == 3'h3 |-> primary_variant ==
    (md == 2'h0 ? VAR_EXT_CLOCK_PLL : md == 2'h1 ? VAR_MEDIUM_XTAL_PLL : md == 2'h2 ? VAR_HIGH_XTAL_PLL : VAR_NONE))
    else $error("pll variant wrong");
  a_pin_xtal: assert property (xtal |-> !osc_pin2_oe) else $error("pin driven in crystal mode");
  a_pin_clk: assert property (up && nv_programmed && nv_mode_word[2] && !xtal |-> osc_pin2_oe)
    else $error("clock output not driven");
  a_pin_clk_out: assert property (up && nv_programmed && nv_mode_word[2] && !xtal
    |-> osc_pin2_o == instr_clk_en) else $error("pin not carrying instruction clock");
  a_cfg_hold: assert property (cnt_q == 2'h3 |-> $stable(switch_enable) && $stable(monitor_enable))
    else $error("latched config changed");
  a_fail_safe: assert property (up && clock_fail && monitor_enable |=> active_source == 3'h0)
    else $error("fail did not fall back");
  a_ready_switch: assert property (start_wait ##0 source_ready |=> active_source == $past(requested_source))
    else $error("ready did not switch source");
  a_lock_one_way: assert property (up && nv_programmed && nv_mode_word[5] && pin_map_locked
    |=> pin_map_locked) else $error("one-way pin lock was released");
endmodule
`default_nettype wire
